//--- hw/wdt_pkg.sv
// constants, register map and types for the watchdog and reset-cause block
package wdt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 20;
    localparam int ASYNC_W = 5;

    // register indices; the byte address is four times the index
    localparam logic [7:0] CTRL_INDEX = 8'h21;
    localparam logic [7:0] CAUSE_INDEX = 8'h20;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] CAUSE_ADDR = {CAUSE_INDEX[5:0], 2'h0};

    // watchdog_control fields
    localparam int IRQ_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int SEL_HI_BIT = 5;
    localparam int UNLOCK_BIT = 4;
    localparam int ENABLE_BIT = 3;
    localparam int SEL_LO_MSB = 2;

    // reset_cause_status fields
    localparam int DOG_CAUSE_BIT = 3;
    localparam int BOR_CAUSE_BIT = 2;
    localparam int PIN_CAUSE_BIT = 1;
    localparam int POR_CAUSE_BIT = 0;
    localparam logic [3:0] CAUSE_AFTER_POR = 4'h1;

    // async input vector positions
    localparam int AS_OSC = 4;
    localparam int AS_FUSE = 3;
    localparam int AS_POR = 2;
    localparam int AS_BOR = 1;
    localparam int AS_PIN = 0;

    // change window and time-out scaling
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [4:0] BASE_SHIFT = 5'h0B;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int OSC_FREQ_HZ = 128000;
    localparam int CLK_FREQ_HZ = 50000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_STOPPED,
        MODE_IRQ,
        MODE_RESET,
        MODE_IRQ_THEN_RESET
    } mode_t;
endpackage

//--- hw/watchdog_and_reset_flags.sv
// watchdog timer control, time-out counter and reset-cause flags behind an AXI4-Lite slave
//
// Contract
// - reset_cause_status bits 7:4 always read as zero.
// - dog_reset_cause_flag set on watchdog reset; cleared by power-on or writing zero.
// - brownout_cause_flag set on brown-out; cleared by power-on or writing zero.
// - pin_reset_cause_flag set on external reset; cleared by power-on or writing zero.
// - power_on_cause_flag set on power-on; cleared only by writing zero.
// - timeout_select msb sits at bit 5, low three bits at 2:0.
// - timeout_irq_flag set on time-out in interrupt mode; cleared by vector or write one.
// - interrupt requested only with global enable set and timeout_irq_enable set or auto-cleared by the time-out.
// - enable/irq-enable pick stopped, interrupt, reset, or interrupt-then-reset action on time-out.
// - with both enables set, time-out clears timeout_irq_enable.
// - change_unlock clears itself four clock cycles after being written one.
// - writing dog_enable zero is ignored unless change_unlock is one.
// - timeout_select writes rejected unless change_unlock is set.
// - safety level 2 never lets the watchdog be disabled.
// - safety level 1 forces dog_enable while dog_reset_cause_flag is set.
// - codes 0 to 9 give 2048 up to 1048576 oscillator cycles, doubling.
// - reserved codes 10 and above fall back to a valid lower setting.
// - counter runs on 128 kHz oscillator; cleared by kick, disable and reset.
// - time-out reset is a one clock cycle pulse.
// - safety_level_fuse picks level; level 2 always enabled, reads enable one.
`timescale 1ns/100ps
module watchdog_and_reset_flags (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [wdt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [wdt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_128k,
    input wire logic safety_level_fuse,
    input wire logic power_on_event,
    input wire logic brownout_event,
    input wire logic pin_reset_event,
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    input wire logic dog_kick,
    output logic timeout_irq,
    output logic dog_reset
);
    import wdt_pkg::*;

    logic [ASYNC_W-1:0] async_s1_q;
    logic [ASYNC_W-1:0] async_s2_q;
    logic osc_s3_q;
    logic osc_tick;
    logic fuse_s;
    logic por_s;
    logic bor_s;
    logic pin_s;

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic do_write;
    logic aw_mapped;
    logic we_ctrl;
    logic we_cause;
    logic rd_take;

    logic irq_flag_q;
    logic irq_en_q;
    logic [3:0] sel_q;
    logic [3:0] sel_eff;
    logic unlock_q;
    logic [2:0] unlock_cnt_q;
    logic enable_q;
    logic enable_eff;
    logic [3:0] cause_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_last;
    logic running;
    logic timeout;
    mode_t mode;
    logic timeout_irq_q;
    logic irq_held_q;
    logic dog_reset_q;
    logic [7:0] ctrl_rd;

    // two-flop synchronisers for the oscillator, fuse and reset-source levels
    always_ff @(posedge aclk) begin
        async_s1_q <= {osc_128k, safety_level_fuse, power_on_event, brownout_event, pin_reset_event};
        async_s2_q <= async_s1_q;
    end

    always_ff @(posedge aclk) begin
        osc_s3_q <= async_s2_q[AS_OSC];
    end

    assign osc_tick = async_s2_q[AS_OSC] & ~osc_s3_q;
    assign fuse_s = async_s2_q[AS_FUSE];
    assign por_s = async_s2_q[AS_POR];
    assign bor_s = async_s2_q[AS_BOR];
    assign pin_s = async_s2_q[AS_PIN];

    // write channel: address and data are held independently, response follows both
    assign do_write = ~awready_q & ~wready_q & ~bvalid_q;
    assign aw_mapped = (awaddr_q == CTRL_ADDR) || (awaddr_q == CAUSE_ADDR);
    assign we_ctrl = do_write & wstrb0_q & (awaddr_q == CTRL_ADDR);
    assign we_cause = do_write & wstrb0_q & (awaddr_q == CAUSE_ADDR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel
    assign rd_take = s_axi_arvalid & arready_q;
    assign ctrl_rd = {irq_flag_q, irq_en_q, sel_q[3], unlock_q, enable_eff, sel_q[2:0]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            if (s_axi_araddr == CTRL_ADDR) begin
                rresp_q <= RESP_OKAY;
                rdata_q <= {24'h000000, ctrl_rd};
            end else if (s_axi_araddr == CAUSE_ADDR) begin
                rresp_q <= RESP_OKAY;
                rdata_q <= {28'h0000000, cause_q};
            end else begin
                rresp_q <= RESP_SLVERR;
                rdata_q <= '0;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // reset-cause flags survive device resets; only a power-on event wipes them
    always_ff @(posedge aclk) begin
        if (por_s) begin
            cause_q <= CAUSE_AFTER_POR;
        end else begin
            cause_q[DOG_CAUSE_BIT] <= dog_reset_q | (cause_q[DOG_CAUSE_BIT] &
                ~(we_cause & ~wdata_q[DOG_CAUSE_BIT]));
            cause_q[BOR_CAUSE_BIT] <= bor_s | (cause_q[BOR_CAUSE_BIT] &
                ~(we_cause & ~wdata_q[BOR_CAUSE_BIT]));
            cause_q[PIN_CAUSE_BIT] <= pin_s | (cause_q[PIN_CAUSE_BIT] &
                ~(we_cause & ~wdata_q[PIN_CAUSE_BIT]));
            cause_q[POR_CAUSE_BIT] <= cause_q[POR_CAUSE_BIT] &
                ~(we_cause & ~wdata_q[POR_CAUSE_BIT]);
        end
    end

    // change window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_q <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (we_ctrl && wdata_q[UNLOCK_BIT]) begin
            unlock_q <= 1'b1;
            unlock_cnt_q <= UNLOCK_CYCLES - 3'h1;
        end else if (unlock_q) begin
            if (unlock_cnt_q == 3'h0) begin
                unlock_q <= 1'b0;
            end else begin
                unlock_cnt_q <= unlock_cnt_q - 3'h1;
            end
        end
    end

    // enable: set freely, cleared only inside the window, level 1 with no dog flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= 1'b0;
        end else if (cause_q[DOG_CAUSE_BIT] || (we_ctrl && wdata_q[ENABLE_BIT])) begin
            enable_q <= 1'b1;
        end else if (we_ctrl && unlock_q && !fuse_s) begin
            enable_q <= 1'b0;
        end
    end

    assign enable_eff = enable_q | fuse_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= 4'h0;
        end else if (we_ctrl && unlock_q) begin
            sel_q <= {wdata_q[SEL_HI_BIT], wdata_q[SEL_LO_MSB:0]};
        end
    end

    assign sel_eff = (sel_q > SEL_MAX) ? SEL_MAX : sel_q;

    // time-out counter on oscillator ticks
    always_comb begin
        unique case ({enable_eff, irq_en_q})
            2'b00: mode = MODE_STOPPED;
            2'b01: mode = MODE_IRQ;
            2'b10: mode = MODE_RESET;
            2'b11: mode = MODE_IRQ_THEN_RESET;
        endcase
    end

    assign running = (mode != MODE_STOPPED);
    assign cnt_last = (CNT_W'(1) << (BASE_SHIFT + {1'b0, sel_eff})) - CNT_W'(1);
    assign timeout = running & osc_tick & ~dog_kick & (cnt_q == cnt_last);

    always_ff @(posedge aclk) begin
        if (!aresetn || !running || dog_kick) begin
            cnt_q <= '0;
        end else if (osc_tick) begin
            cnt_q <= (cnt_q == cnt_last) ? '0 : cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_q <= 1'b0;
        end else if (we_ctrl) begin
            irq_en_q <= wdata_q[IRQ_EN_BIT];
        end else if (timeout && mode == MODE_IRQ_THEN_RESET) begin
            irq_en_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_flag_q <= 1'b0;
        end else if (timeout && irq_en_q) begin
            irq_flag_q <= 1'b1;
        end else if (irq_vector_taken || (we_ctrl && wdata_q[IRQ_FLAG_BIT])) begin
            irq_flag_q <= 1'b0;
        end
    end

    // keeps the request alive after the time-out has auto-cleared irq enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_held_q <= 1'b0;
        end else if (timeout && mode == MODE_IRQ_THEN_RESET) begin
            irq_held_q <= 1'b1;
        end else if (!irq_flag_q || we_ctrl) begin
            irq_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_irq_q <= 1'b0;
            dog_reset_q <= 1'b0;
        end else begin
            timeout_irq_q <= irq_flag_q & (irq_en_q | irq_held_q) & global_irq_enable;
            dog_reset_q <= timeout & (mode == MODE_RESET);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign timeout_irq = timeout_irq_q;
    assign dog_reset = dog_reset_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_unlock_set;
        we_ctrl && wdata_q[UNLOCK_BIT];
    endsequence

    sequence s_reset_pulse;
        dog_reset_q ##1 !dog_reset_q;
    endsequence

    AST_CAUSE_RESERVED: assert property ((rd_take && s_axi_araddr == CAUSE_ADDR) |=> rdata_q[7:4] == 4'h0)
        else $error("reserved cause bits read non-zero");
    AST_DOG_FLAG_SET: assert property ((dog_reset_q && !por_s) |=> cause_q[DOG_CAUSE_BIT])
        else $error("watchdog cause flag not set");
    AST_BOR_FLAG_SET: assert property ((bor_s && !por_s) |=> cause_q[BOR_CAUSE_BIT])
        else $error("brown-out cause flag not set");
    AST_PIN_FLAG_SET: assert property ((pin_s && !por_s) |=> cause_q[PIN_CAUSE_BIT])
        else $error("pin cause flag not set");
    AST_POR_CLEARS: assert property (por_s |=> cause_q == CAUSE_AFTER_POR)
        else $error("power-on did not leave only its own flag");
    AST_SEL_SPLIT: assert property ((we_ctrl && unlock_q) |=>
        sel_q == {$past(wdata_q[SEL_HI_BIT]), $past(wdata_q[SEL_LO_MSB:0])})
        else $error("select field not taken from bits 5 and 2:0");
    AST_IRQ_FLAG: assert property ((timeout && irq_en_q) |=> irq_flag_q)
        else $error("time-out flag not set in interrupt mode");
    AST_IRQ_OUT: assert property ((irq_flag_q && irq_en_q && global_irq_enable) |=> timeout_irq_q)
        else $error("interrupt not requested");
    AST_RESET_PULSE: assert property ((timeout && mode == MODE_RESET) |=> s_reset_pulse)
        else $error("reset pulse not exactly one cycle");
    AST_IRQ_EN_AUTO: assert property ((timeout && mode == MODE_IRQ_THEN_RESET && !we_ctrl) |=> !irq_en_q)
        else $error("irq enable not cleared by time-out");
    AST_UNLOCK_HOLD: assert property (s_unlock_set |=> unlock_q [*4])
        else $error("unlock dropped early");
    AST_UNLOCK_END: assert property ((s_unlock_set ##1 (!(we_ctrl && wdata_q[UNLOCK_BIT])) [*4]) |=> !unlock_q)
        else $error("unlock not cleared after four cycles");
    AST_ENABLE_LOCKED: assert property ((we_ctrl && !unlock_q && enable_q) |=> enable_q)
        else $error("enable cleared outside window");
    AST_SEL_LOCKED: assert property ((we_ctrl && !unlock_q) |=> $stable(sel_q))
        else $error("select changed outside window");
    AST_LEVEL2_ON: assert property ((rd_take && s_axi_araddr == CTRL_ADDR && fuse_s) |=> rdata_q[ENABLE_BIT])
        else $error("level 2 enable read zero");
    AST_LEVEL1_FORCE: assert property ((cause_q[DOG_CAUSE_BIT] && aresetn) |=> enable_q)
        else $error("enable not forced by dog flag");
    AST_SEL_CLAMP: assert property ((sel_q > SEL_MAX) |-> cnt_last == {CNT_W{1'b1}})
        else $error("reserved select not clamped");
    AST_KICK_CLEARS: assert property (dog_kick |=> cnt_q == '0)
        else $error("kick did not clear counter");
    AST_IRQ_HELD: assert property ((irq_flag_q && irq_held_q && global_irq_enable) |=> timeout_irq_q)
        else $error("interrupt lost after irq enable auto-clear");
    AST_IRQ_GATED: assert property (!global_irq_enable |=> !timeout_irq_q)
        else $error("interrupt requested with global enable low");

endmodule // watchdog_and_reset_flags

//--- verification/core_sw_model.sv
// software-side model reaching the registers over the AXI4-Lite bus
`timescale 1ns/100ps
module core_sw_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        // always ready for responses so a disable write lands inside the change window
        s_axi_bready = 1'b1;
    end

    // called right after a rising edge; handshakes sampled mid-cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_ok, w_ok, b_ok;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_ok, r_ok;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule // core_sw_model

//--- verification/tb.sv
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/100ps
module tb;
    import wdt_pkg::*;
    logic aclk, aresetn, osc_128k, safety_level_fuse, power_on_event, brownout_event, pin_reset_event;
    logic global_irq_enable, irq_vector_taken, dog_kick, timeout_irq, dog_reset, dr_q;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ctrl_m, cause_m;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int failures = 0, num_checks = 0, cyc = 0, resets = 0, wide = 0, n;
    time unl_t = 0;

    watchdog_and_reset_flags DUT (.*);
    core_sw_model u_sw (.*);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // watchdog oscillator, fast in simulation: one tick every four clocks
    initial begin
        osc_128k = 1'b0;
        #7;
        forever #40 osc_128k = ~osc_128k;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        dr_q <= dog_reset;
        if (dog_reset) resets <= resets + 1;
        if (dog_reset && dr_q) wide <= wide + 1;
        if (cyc == 70000) begin
            failures++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // bus write plus the register model
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic unl;
        unl = ($time - unl_t) < 20;
        u_sw.wr(a, {24'h0, d}, rs);
        check(rs, (a == CTRL_ADDR || a == CAUSE_ADDR) ? RESP_OKAY : RESP_SLVERR);
        if (a == CAUSE_ADDR) cause_m = cause_m & d;
        if (a == CTRL_ADDR) begin
            if (d[7]) ctrl_m[7] = 1'b0;
            ctrl_m[6] = d[6];
            if (unl) {ctrl_m[5], ctrl_m[2:0]} = {d[5], d[2:0]};
            if (d[3]) ctrl_m[3] = 1'b1;
            else if (unl && !safety_level_fuse && !cause_m[3]) ctrl_m[3] = 1'b0;
            if (d[4]) unl_t = $time;
        end
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        u_sw.rd(a, rv, rs);
        check(rv, {24'h0, exp});
    endtask

    task automatic wait_for(input bit irq, output int cnt);
        cnt = 0;
        do begin
            @(negedge aclk);
            cnt++;
        end while (!(irq ? timeout_irq : dog_reset) && cnt < 10000);
        @(posedge aclk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {aresetn, safety_level_fuse, brownout_event, pin_reset_event} = '0;
        {global_irq_enable, irq_vector_taken, dog_kick} = '0;
        power_on_event = 1'b1;
        ctrl_m = 8'h00;
        cause_m = 8'h01;
        void'($urandom(84));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        power_on_event <= 1'b0;
        repeat (4) @(posedge aclk);
        reg_rd(CAUSE_ADDR, cause_m);
        u_sw.rd(8'h10, rv, rs);
        check(rs, RESP_SLVERR);
        reg_wr(8'h10, 8'hFF);
        reg_rd(CTRL_ADDR, ctrl_m);
        reg_wr(CAUSE_ADDR, 8'h00);
        reg_rd(CAUSE_ADDR, cause_m);
        sel = 4'($urandom);
        reg_wr(CTRL_ADDR, {2'b00, sel[3], 2'b00, sel[2:0]});
        reg_rd(CTRL_ADDR, ctrl_m);
        reg_wr(CTRL_ADDR, 8'h18);
        reg_wr(CTRL_ADDR, {2'b00, sel[3], 2'b01, sel[2:0]});
        reg_rd(CTRL_ADDR, ctrl_m);
        reg_wr(CTRL_ADDR, 8'h18);
        reg_wr(CTRL_ADDR, 8'h08);
        reg_wr(CTRL_ADDR, 8'h18);
        repeat (6) @(posedge aclk);
        reg_wr(CTRL_ADDR, 8'h00);
        reg_rd(CTRL_ADDR, ctrl_m);
        $display("test registers finished");

        repeat (12) begin
            dog_kick <= 1'b1;
            @(posedge aclk);
            dog_kick <= 1'b0;
            repeat ($urandom_range(900, 1100)) @(posedge aclk);
        end
        check(resets, 0);
        dog_kick <= 1'b1;
        @(posedge aclk);
        dog_kick <= 1'b0;
        wait_for(1'b0, n);
        check(n > 8180 && n < 8215, 1);
        repeat (3) @(posedge aclk);
        check(wide, 0);
        cause_m = 8'h08;
        reg_rd(CAUSE_ADDR, cause_m);
        reg_wr(CTRL_ADDR, 8'h18);
        reg_wr(CTRL_ADDR, 8'h00);
        reg_rd(CTRL_ADDR, ctrl_m);
        reg_wr(CAUSE_ADDR, 8'h00);
        reg_wr(CTRL_ADDR, 8'h18);
        reg_wr(CTRL_ADDR, 8'h00);
        reg_rd(CTRL_ADDR, ctrl_m);
        $display("test reset_mode finished");

        reg_wr(CTRL_ADDR, 8'h40);
        repeat (8400) @(posedge aclk);
        @(negedge aclk);
        check(timeout_irq, 1'b0);
        @(posedge aclk);
        ctrl_m[7] = 1'b1;
        reg_rd(CTRL_ADDR, ctrl_m);
        global_irq_enable <= 1'b1;
        repeat (3) @(negedge aclk);
        check(timeout_irq, 1'b1);
        @(posedge aclk);
        irq_vector_taken <= 1'b1;
        @(posedge aclk);
        irq_vector_taken <= 1'b0;
        ctrl_m[7] = 1'b0;
        reg_rd(CTRL_ADDR, ctrl_m);
        @(negedge aclk);
        check(timeout_irq, 1'b0);
        @(posedge aclk);
        wait_for(1'b1, n);
        check(n > 7800 && n < 8100, 1);
        reg_wr(CTRL_ADDR, 8'h80);
        reg_rd(CTRL_ADDR, ctrl_m);
        check(resets, 1);
        $display("test irq_mode finished");

        reg_wr(CTRL_ADDR, 8'h48);
        wait_for(1'b1, n);
        check(n < 10000, 1);
        ctrl_m = 8'h88;
        reg_rd(CTRL_ADDR, ctrl_m);
        wait_for(1'b0, n);
        check(n > 8170 && n < 8200, 1);
        @(negedge aclk);
        check(resets, 2);
        @(posedge aclk);
        cause_m = 8'h08;
        for (int i = 0; i < 2; i++) begin
            if (i == 0) pin_reset_event <= 1'b1;
            else brownout_event <= 1'b1;
            repeat (4) @(posedge aclk);
            pin_reset_event <= 1'b0;
            brownout_event <= 1'b0;
            repeat (4) @(posedge aclk);
            cause_m[i+1] = 1'b1;
            reg_rd(CAUSE_ADDR, cause_m);
        end
        power_on_event <= 1'b1;
        repeat (4) @(posedge aclk);
        power_on_event <= 1'b0;
        repeat (4) @(posedge aclk);
        cause_m = 8'h01;
        reg_rd(CAUSE_ADDR, cause_m);
        safety_level_fuse <= 1'b1;
        repeat (4) @(posedge aclk);
        reg_wr(CTRL_ADDR, 8'h18);
        reg_wr(CTRL_ADDR, 8'h00);
        reg_rd(CTRL_ADDR, ctrl_m);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        ctrl_m = 8'h08;
        reg_rd(CTRL_ADDR, ctrl_m);
        reg_rd(CAUSE_ADDR, cause_m);
        $display("test causes_and_level2 finished");
        complete_run();
    end
endmodule // tb
